// ===== logic/cps_regs.svh
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH

// Register offsets on page 0
`define CPS_OFS_INPUT_EN        8'h73
`define CPS_OFS_SLOT_EN         8'h74
`define CPS_OFS_POWER_CFG       8'h75
`define CPS_OFS_POWER_STS       8'h76
`define CPS_OFS_OVERALL_MODE_CODE        8'h77

// Reset values
`define CPS_RST_INPUT_EN        8'hF0
`define CPS_RST_SLOT_EN         8'h00
`define CPS_RST_POWER_CFG       8'h00
`define CPS_RST_POWER_STS       8'h00

// Power configuration field positions
`define CPS_BIT_MIC_BIAS        7
`define CPS_BIT_CONV_ON         6
`define CPS_BIT_PLL_ON          5
`define CPS_BIT_DYN_EN          4
`define CPS_POS_RANGE_HI        3
`define CPS_POS_RANGE_LO        2
`define CPS_MASK_POWER_CFG      8'hFC

// Mode codes, upper three bits of the mode status byte
`define CPS_MODE_SLEEP          3'h4
`define CPS_MODE_ACTIVE_IDLE    3'h6
`define CPS_MODE_ACTIVE_REC     3'h7

// Channel settling time
`define CPS_SETTLE_NS           1000
`define CPS_CLK_NS              25
`define CPS_SETTLE_CYC          ((`CPS_SETTLE_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS)

`endif

// ===== logic/cps_pkg.sv
package cps_pkg;

   typedef enum logic [1:0] {
      CPS_RANGE_1_2,
      CPS_RANGE_1_4,
      CPS_RANGE_1_6,
      CPS_RANGE_1_8
   } cps_range_t;

   typedef struct packed {
      logic       mic_bias_power_on;
      logic       converter_channels_power_on;
      logic       pll_power_on;
      logic       per_channel_power_switch_en;
      cps_range_t switchable_channel_range;
      logic [1:0] reserved;
   } cps_power_cfg_t;

   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cps_reg_req_t;

   typedef struct packed {
      logic [7:0] input_channel_enables;
      logic [7:0] slot_drive_en;
      cps_power_cfg_t power_cfg;
      logic [7:0] powered;
      logic [7:0] target;
      logic [7:0] timer;
      logic [2:0] chan;
      logic       busy;
      logic [7:0] rdata;
      logic [7:0] slot_oe;
      logic       mic_bias_on;
      logic       pll_on;
      logic [2:0] overall_mode_code;
   } cps_state_t;

endpackage

// ===== logic/cps_channel_power.sv
`timescale 1ns/1ps
`default_nettype none
`include "cps_regs.svh"

// Summary of operation
// - Eight slot drive enables, bit 7 for channel 1 to bit 0 for channel 8, drive a slot when set and float it when clear.
// - All slot drive enables reset to zero so no slot is driven before software enables it.
// - Power configuration bit 7 switches the microphone bias supply on when set and off when clear.
// - Power configuration bit 6 powers down every channel when clear and powers up only input-enabled channels when set.
// - Power configuration bit 5 switches the PLL on when set and off when clear.
// - With bit 4 clear, individual channel changes are not made while any channel is recording.
// - With bit 4 set, each channel in the switchable set may be powered up or down alone while others keep recording.
// - Bits 3-2 pick the switchable channel set: 0 is channels 1-2, 1 is 1-4, 2 is 1-6, 3 is 1-8.
// - The power configuration register resets to zero, leaving everything powered down and switching off.
// - A read-only status byte shows one per powered channel, bit 7 for channel 1 to bit 0 for channel 8.
// - Status for channels 5 to 8 covers PDM channels only, having no analog converter path.
// - Input enables use bit 7 for channel 1 to bit 0 for channel 8, channels 5-8 are PDM only, reset value F0h.
// - The mode code reads 4 asleep, 6 active with all channels off, and 7 with at least one channel on.
module cps_channel_power
(
   // Clock and reset
   input  wire logic                 clock_i,
   input  wire logic                 arst_n_i,
   // Register access port
   input  wire cps_pkg::cps_reg_req_t reg_req_i,
   output logic [7:0]                reg_rdata_o,
   // Channel power and slot control
   output logic [7:0]                slot_oe_o,
   output logic [7:0]                chan_power_o,
   output logic                      mic_bias_supply_o,
   output logic                      pll_power_o,
   output logic [2:0]                overall_mode_code_o
);

   localparam logic [7:0] SETTLE_CYC = 8'(`CPS_SETTLE_CYC);

   cps_pkg::cps_state_t state;
   cps_pkg::cps_state_t next_state;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      logic [7:0] want;
      logic [7:0] range_mask;
      logic       recording;
      logic       locked;
      logic [2:0] bit_idx;
      want       = 8'h00;
      range_mask = 8'h00;
      recording  = 1'b0;
      locked     = 1'b0;
      bit_idx    = 3'h0;
      next_state = state;

      // Register writes; status and mode bytes ignore writes
      if (state.busy == 1'b0 && reg_req_i.wr_en)
      begin
         case (reg_req_i.addr)
            `CPS_OFS_INPUT_EN:
               next_state.input_channel_enables = reg_req_i.wdata;
            `CPS_OFS_SLOT_EN:
               next_state.slot_drive_en = reg_req_i.wdata;
            `CPS_OFS_POWER_CFG:
               next_state.power_cfg = reg_req_i.wdata;
            default:
               next_state.rdata = state.rdata;
         endcase
      end
      // Writes while a channel is settling are still taken; busy only gates
      // against the mid-sequence case below.
      if (state.busy == 1'b1 && reg_req_i.wr_en)
      begin
         case (reg_req_i.addr)
            `CPS_OFS_INPUT_EN:  next_state.input_channel_enables = reg_req_i.wdata;
            `CPS_OFS_SLOT_EN:   next_state.slot_drive_en = reg_req_i.wdata;
            `CPS_OFS_POWER_CFG: next_state.power_cfg = reg_req_i.wdata;
            default:            next_state.rdata = state.rdata;
         endcase
      end

      // Reads
      if (reg_req_i.rd_en)
      begin
         case (reg_req_i.addr)
            `CPS_OFS_INPUT_EN:  next_state.rdata = state.input_channel_enables;
            `CPS_OFS_SLOT_EN:   next_state.rdata = state.slot_drive_en;
            `CPS_OFS_POWER_CFG: next_state.rdata = state.power_cfg;
            `CPS_OFS_POWER_STS: next_state.rdata = state.powered;
            `CPS_OFS_OVERALL_MODE_CODE:  next_state.rdata = {state.overall_mode_code, 5'h00};
            default:            next_state.rdata = 8'h00;
         endcase
      end

      // Desired channel power set
      want = state.power_cfg.converter_channels_power_on ?
             state.input_channel_enables : 8'h00;

      // Channels open to individual switching
      case (state.power_cfg.switchable_channel_range)
         cps_pkg::CPS_RANGE_1_2: range_mask = 8'hC0;
         cps_pkg::CPS_RANGE_1_4: range_mask = 8'hF0;
         cps_pkg::CPS_RANGE_1_6: range_mask = 8'hFC;
         cps_pkg::CPS_RANGE_1_8: range_mask = 8'hFF;
         default:                range_mask = 8'h00;
      endcase

      recording = |state.powered;
      // Without dynamic switching, the set chosen when recording began is
      // completed, and later enable changes wait until every channel is down
      // or the global power bit drops, so live channels are not disturbed.
      if (state.power_cfg.per_channel_power_switch_en)
         want = (want & range_mask) | (state.powered & ~range_mask & want);
      else if (recording && state.power_cfg.converter_channels_power_on)
         locked = 1'b1;
      if (locked)
         want = state.target;

      // One channel at a time settles, highest bit (channel 1) first
      if (state.busy)
      begin
         if (state.timer == 8'h00)
         begin
            next_state.busy = 1'b0;
            next_state.powered[state.chan] = state.target[state.chan];
         end
         else
            next_state.timer = state.timer - 8'h01;
      end
      else
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (want[i] != state.powered[i])
               bit_idx = 3'(i);
         end
         if (want != state.powered)
         begin
            next_state.busy   = 1'b1;
            next_state.chan   = bit_idx;
            next_state.target = want;
            next_state.timer  = SETTLE_CYC - 8'h01;
         end
      end

      // Outputs
      next_state.slot_oe     = state.slot_drive_en;
      next_state.mic_bias_on = state.power_cfg.mic_bias_power_on;
      next_state.pll_on      = state.power_cfg.pll_power_on;
      if (!state.power_cfg.converter_channels_power_on && state.powered == 8'h00)
         next_state.overall_mode_code = `CPS_MODE_SLEEP;
      else if (state.powered == 8'h00)
         next_state.overall_mode_code = `CPS_MODE_ACTIVE_IDLE;
      else
         next_state.overall_mode_code = `CPS_MODE_ACTIVE_REC;
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state                       <= '0;
         state.input_channel_enables <= `CPS_RST_INPUT_EN;
         state.slot_drive_en         <= `CPS_RST_SLOT_EN;
         state.power_cfg             <= `CPS_RST_POWER_CFG;
         state.powered               <= `CPS_RST_POWER_STS;
         state.overall_mode_code     <= `CPS_MODE_SLEEP;
      end
      else
         state <= next_state;
   end

   assign reg_rdata_o         = state.rdata;
   assign slot_oe_o           = state.slot_oe;
   assign chan_power_o        = state.powered;
   assign mic_bias_supply_o   = state.mic_bias_on;
   assign pll_power_o         = state.pll_on;
   assign overall_mode_code_o = state.overall_mode_code;

endmodule

`default_nettype wire

// ===== verification/cps_channel_power_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cps_channel_power_asserts
(
   // Clock and reset
   input wire logic                  clock_i,
   input wire logic                  arst_n_i,
   // Watched ports
   input wire cps_pkg::cps_reg_req_t reg_req_i,
   input wire logic [7:0]            reg_rdata_o,
   input wire logic [7:0]            slot_oe_o,
   input wire logic [7:0]            chan_power_o,
   input wire logic                  mic_bias_supply_o,
   input wire logic                  pll_power_o,
   input wire logic [2:0]            overall_mode_code_o
);
   logic wr74;
   logic wr75;
   assign wr74 = reg_req_i.wr_en && reg_req_i.addr == 8'h74;
   assign wr75 = reg_req_i.wr_en && reg_req_i.addr == 8'h75;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   // ----------------------------------------
   // Write effects and read returns
   // ----------------------------------------
   chk_slot_follow: assert property (wr74 |-> ##2 slot_oe_o == $past(reg_req_i.wdata, 2))
      else $error("slot enables do not follow the write");
   chk_bias_follow: assert property (wr75 |-> ##2 mic_bias_supply_o == $past(reg_req_i.wdata[7], 2))
      else $error("bias supply does not follow bit 7");
   chk_pll_follow: assert property (wr75 |-> ##2 pll_power_o == $past(reg_req_i.wdata[5], 2))
      else $error("pll power does not follow bit 5");
   chk_cfg_readback: assert property (wr75 ##1 (reg_req_i.rd_en && reg_req_i.addr == 8'h75)
      |=> reg_rdata_o == $past(reg_req_i.wdata, 2)) else $error("config readback differs");
   chk_sts_read: assert property (reg_req_i.rd_en && reg_req_i.addr == 8'h76
      |=> reg_rdata_o == $past(chan_power_o)) else $error("status read differs from flags");
   chk_unmapped_zero: assert property (reg_req_i.rd_en && !(reg_req_i.addr inside {[8'h73:8'h77]})
      |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
   // Channels settle one after another, so flags never move on adjacent cycles
   chk_sts_spacing: assert property ($changed(chan_power_o) |=> $stable(chan_power_o)[*8])
      else $error("channel flags changed too quickly");
   chk_mode_rec: assert property ((chan_power_o != 8'h00)[*2] |-> overall_mode_code_o == 3'h7)
      else $error("mode not recording while a channel is on");
   chk_reset_quiet: assert property (disable iff (1'b0) !arst_n_i |-> slot_oe_o == 8'h00
      && !mic_bias_supply_o && !pll_power_o && overall_mode_code_o == 3'h4)
      else $error("outputs not quiet in reset");
endmodule
bind cps_channel_power cps_channel_power_asserts u_chk (.clock_i(clock_i), .arst_n_i(arst_n_i),
   .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .slot_oe_o(slot_oe_o),
   .chan_power_o(chan_power_o), .mic_bias_supply_o(mic_bias_supply_o),
   .pll_power_o(pll_power_o), .overall_mode_code_o(overall_mode_code_o));
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                  clock_i = 1'b0;
   logic                  arst_n_i = 1'b1;
   cps_pkg::cps_reg_req_t req = '0;
   logic [7:0]            rdata, slot_oe, pwr, v;
   logic                  bias, pll;
   logic                  pend = 1'b0;
   logic [2:0]            mode;
   logic [7:0]            q[$];
   int                    fail_count = 0, compares = 0, cyc = 0, i;
   always #12.5 clock_i = ~clock_i;
   cps_channel_power dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .reg_req_i(req),
      .reg_rdata_o(rdata), .slot_oe_o(slot_oe), .chan_power_o(pwr),
      .mic_bias_supply_o(bias), .pll_power_o(pll), .overall_mode_code_o(mode));
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // Requests are launched at the falling edge and held across one rising edge
   task automatic op(logic w, logic r, logic [7:0] a, logic [7:0] d);
      @(negedge clock_i);
      req = '{wr_en: w, rd_en: r, addr: a, wdata: d};
      @(posedge clock_i);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      q.push_back(e);
      op(1'b0, 1'b1, a, 8'($urandom));
   endtask
   task automatic idle(int n);
      @(negedge clock_i);
      req = '0;
      repeat (n) @(negedge clock_i);
   endtask
   task automatic wait_pwr(logic [7:0] e, int n);
      for (int k = 0; k < n && pwr !== e; k++) @(negedge clock_i);
      chk("chan_power", e, pwr);
   endtask
   task automatic summarize();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // Read data monitor and hang guard
   // ----------------------------------------
   always @(posedge clock_i) pend <= req.rd_en;
   always @(negedge clock_i)
      if (pend)
         chk("reg_rdata", (q.size() > 0) ? q.pop_front() : 8'hXX, rdata);
   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         fail_count++;
         summarize();
      end
   end
   initial
   begin
      arst_n_i = 1'b0;
      void'($urandom(81));
      repeat (6) @(negedge clock_i);
      arst_n_i = 1'b1;
      rd(8'h73, 8'hF0);
      rd(8'h74, 8'h00);
      rd(8'h75, 8'h00);
      rd(8'h76, 8'h00);
      rd(8'h77, 8'h80);
      for (i = 0; i < 4; i++)
      begin
         v = 8'($urandom);
         op(1'b1, 1'b0, 8'h74, v);
         rd(8'h74, v);
         idle(1);
         chk("slot_oe", v, slot_oe);
      end
      op(1'b1, 1'b0, 8'h76, 8'hFF);
      rd(8'h76, 8'h00);
      rd(8'h10, 8'h00);
      op(1'b1, 1'b0, 8'h73, 8'hC0);
      op(1'b1, 1'b0, 8'h75, 8'hE0);
      rd(8'h75, 8'hE0);
      idle(2);
      chk("bias_pll", 8'h03, {6'h00, bias, pll});
      wait_pwr(8'hC0, 200);
      rd(8'h77, 8'hE0);
      op(1'b1, 1'b0, 8'h73, 8'hFF);
      idle(100);
      chk("chan_power", 8'hC0, pwr);
      for (i = 0; i < 4; i++)
      begin
         op(1'b1, 1'b0, 8'h75, 8'hF0 | 8'(i << 2));
         idle(2);
         wait_pwr(8'hFF << (6 - 2 * i), 400);
      end
      op(1'b1, 1'b0, 8'h75, 8'h00);
      idle(2);
      chk("bias_pll", 8'h00, {6'h00, bias, pll});
      wait_pwr(8'h00, 600);
      idle(2);
      summarize();
   end
endmodule
`default_nettype wire
